// *** frame_consts.vh ***
// Constants for the procedure frame builder.
// Assumes a 32-bit doubleword stack memory port with byte addresses.
`ifndef FRAME_CONSTS_VH
`define FRAME_CONSTS_VH
`define DW_BYTES        32'h0000_0004
`define LEVEL_W         5
`define LEVEL_MAX       5'h1f
`define STORAGE_W       16
`define PTR_RESET       32'h0000_0000
`define SYNC_STAGES     2
`define MEM_TIMEOUT_NS  100000
`define CLK_PERIOD_NS   50
`define MEM_TIMEOUT_CYC ((`MEM_TIMEOUT_NS) / (`CLK_PERIOD_NS))
`endif

// *** ptr_store.v ***
// Two-word pointer store holding the frame base and stack top pointers.
// Assumes the caller provides one write per word per cycle at most.
`timescale 1ns/100ps
`default_nettype none
module ptr_store (
  // Clock and reset.
  input  wire        clk,
  input  wire        rst_n,
  // Write side.
  input  wire        wr_fb,
  input  wire [31:0] wdata_fb,
  input  wire        wr_st,
  input  wire [31:0] wdata_st,
  input  wire        ld_fb,
  input  wire [31:0] ldata_fb,
  input  wire        ld_st,
  input  wire [31:0] ldata_st,
  // Read side.
  output reg  [31:0] fb_r,
  output reg  [31:0] st_r
);
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fb_r <= 32'h0000_0000;
      st_r <= 32'h0000_0000;
    end else begin
      if (ld_fb)
        fb_r <= ldata_fb;
      else if (wr_fb)
        fb_r <= wdata_fb;
      if (ld_st)
        st_r <= ldata_st;
      else if (wr_st)
        st_r <= wdata_st;
    end
  end
endmodule
`default_nettype wire

// *** frame_builder.v ***
// Frame creation and release sequencer on a doubleword stack memory port.
// Assumes a request and acknowledge memory port on the same clock.
`include "frame_consts.vh"
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// [RULE1] First operand is local storage byte count.
// [RULE2] Second operand is nesting depth zero to 31.
// [RULE3] Depth ignores and never touches privilege levels.
// [RULE4] Depth zero: push base, base=top, subtract storage.
// [RULE5] Nonzero: copy depth minus one outer pointers.
// [RULE6] Each display pointer is one doubleword.
// [RULE7] First display word is previous frame pointer.
// [RULE8] Finally lower top by storage byte count.
// [RULE9] Base ends addressing first, highest display word.
// [RULE10] Base-relative data accesses use stack segment.
// [RULE11] Depth one copies no earlier pointers.
// [RULE12] Same depth call omits caller's own pointer.
// [RULE13] Re-entry treated as same depth call.
// [RULE14] Release: top=base, then pop old base.
// [RULE15] Memory port completes each access in order.
// [RULE16] Done only after final stack top update.
module frame_builder (
  // Clock and reset.
  input  wire                  clk,
  input  wire                  rstn,
  // Command port.
  input  wire                  enter_req,
  input  wire                  leave_req,
  input  wire [`STORAGE_W-1:0] storage_bytes,
  input  wire [`LEVEL_W-1:0]   nest_level,
  output wire                  cmd_ready,
  output reg                   done_r,
  // Stack memory port.
  output reg                   mem_req_r,
  output reg                   mem_we_r,
  output reg  [31:0]           mem_addr_r,
  output reg  [31:0]           mem_wdata_r,
  input  wire                  mem_ack,
  input  wire [31:0]           mem_rdata,
  // Pointer state and segment select.
  output wire [31:0]           frame_base_pointer,
  output wire [31:0]           stack_top_pointer,
  input  wire                  base_is_frame_reg,
  output wire                  use_stack_seg
);
  ////////////////////////////////////////////////////////////////////////
  reg rst_s1_r;
  reg rst_s2_r;
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end
  wire rst_n = rst_s2_r;
  ////////////////////////////////////////////////////////////////////////
  localparam [2:0] S_IDLE = 3'h0;
  localparam [2:0] S_PUSH = 3'h1;
  localparam [2:0] S_RD   = 3'h2;
  localparam [2:0] S_WR   = 3'h3;
  localparam [2:0] S_LINK = 3'h4;
  localparam [2:0] S_FIN  = 3'h5;
  localparam [2:0] S_POP  = 3'h6;

  reg  [2:0]            state_r;
  reg  [`LEVEL_W-1:0]   count_r;
  reg  [`LEVEL_W-1:0]   level_r;
  reg  [`STORAGE_W-1:0] storage_r;
  reg  [31:0]           saved_frame_value_r;
  reg                   wr_fb;
  reg  [31:0]           wdata_fb;
  reg                   wr_st;
  reg  [31:0]           wdata_st;
  wire [31:0]           fb;
  wire [31:0]           st;

  ptr_store u_ptrs (
    .clk      (clk),
    .rst_n    (rst_n),
    .wr_fb    (wr_fb),
    .wdata_fb (wdata_fb),
    .wr_st    (wr_st),
    .wdata_st (wdata_st),
    .ld_fb    (1'b0),
    .ldata_fb (32'h0000_0000),
    .ld_st    (1'b0),
    .ldata_st (32'h0000_0000),
    .fb_r     (fb),
    .st_r     (st)
  );

  assign frame_base_pointer = fb;
  assign stack_top_pointer  = st;
  assign cmd_ready          = (state_r == S_IDLE);
  assign use_stack_seg      = base_is_frame_reg; // see [RULE10]
  ////////////////////////////////////////////////////////////////////////
  // Pointer updates happen on acknowledged steps, and in S_FIN without an acknowledge.
  always @* begin
    wr_fb    = 1'b0;
    wdata_fb = fb;
    wr_st    = 1'b0;
    wdata_st = st;
    case (state_r)
      S_PUSH: begin
        if (mem_ack) begin
          wr_st    = 1'b1;
          wdata_st = st - `DW_BYTES;
        end
      end
      S_RD: begin
        if (mem_ack) begin
          wr_fb    = 1'b1;
          wdata_fb = fb - `DW_BYTES; // see [RULE5]
        end
      end
      S_WR, S_LINK: begin
        if (mem_ack) begin
          wr_st    = 1'b1;
          wdata_st = st - `DW_BYTES; // see [RULE6]
        end
      end
      S_FIN: begin
        wr_fb    = 1'b1;
        wdata_fb = saved_frame_value_r; // see [RULE9]
        wr_st    = 1'b1;
        wdata_st = st - {16'h0000, storage_r}; // see [RULE8]
      end
      S_POP: begin
        if (mem_ack) begin
          wr_fb    = 1'b1;
          wdata_fb = mem_rdata;
          wr_st    = 1'b1;
          wdata_st = fb + `DW_BYTES; // see [RULE14]
        end
      end
      default: begin
        wr_fb = 1'b0;
      end
    endcase
  end
  ////////////////////////////////////////////////////////////////////////
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r             <= S_IDLE;
      count_r             <= 5'h00;
      level_r             <= 5'h00;
      storage_r           <= 16'h0000;
      saved_frame_value_r <= 32'h0000_0000;
      done_r              <= 1'b0;
      mem_req_r           <= 1'b0;
      mem_we_r            <= 1'b0;
      mem_addr_r          <= 32'h0000_0000;
      mem_wdata_r         <= 32'h0000_0000;
    end else begin
      done_r <= 1'b0;
      case (state_r)
        S_IDLE: begin
          if (enter_req) begin
            storage_r   <= storage_bytes; // see [RULE1]
            level_r     <= nest_level;    // see [RULE2] see [RULE3]
            mem_req_r   <= 1'b1;
            mem_we_r    <= 1'b1;
            mem_addr_r  <= st - `DW_BYTES;
            mem_wdata_r <= fb; // see [RULE7]
            state_r     <= S_PUSH;
          end else if (leave_req) begin
            mem_req_r  <= 1'b1;
            mem_we_r   <= 1'b0;
            mem_addr_r <= fb;
            state_r    <= S_POP;
          end
        end
        S_PUSH: begin
          if (mem_ack) begin // see [RULE15]
            saved_frame_value_r <= st - `DW_BYTES;
            if (level_r == 5'h00) begin
              mem_req_r <= 1'b0;
              state_r   <= S_FIN; // see [RULE4]
            end else if (level_r == 5'h01) begin
              mem_we_r    <= 1'b1; // see [RULE11]
              mem_addr_r  <= st - 32'h0000_0008;
              mem_wdata_r <= st - `DW_BYTES;
              state_r     <= S_LINK;
            end else begin
              count_r    <= level_r - 5'h01; // see [RULE12] see [RULE13]
              mem_we_r   <= 1'b0;
              mem_addr_r <= fb - `DW_BYTES;
              state_r    <= S_RD;
            end
          end
        end
        S_RD: begin
          if (mem_ack) begin
            mem_we_r    <= 1'b1;
            mem_addr_r  <= st - `DW_BYTES;
            mem_wdata_r <= mem_rdata;
            count_r     <= count_r - 5'h01;
            state_r     <= S_WR;
          end
        end
        S_WR: begin
          if (mem_ack) begin
            if (count_r == 5'h00) begin
              mem_addr_r  <= st - 32'h0000_0008;
              mem_wdata_r <= saved_frame_value_r;
              state_r     <= S_LINK;
            end else begin
              mem_we_r   <= 1'b0;
              mem_addr_r <= fb - `DW_BYTES;
              state_r    <= S_RD;
            end
          end
        end
        S_LINK: begin
          if (mem_ack) begin
            mem_req_r <= 1'b0;
            mem_we_r  <= 1'b0;
            state_r   <= S_FIN;
          end
        end
        S_FIN: begin
          done_r  <= 1'b1; // see [RULE16]
          state_r <= S_IDLE;
        end
        S_POP: begin
          if (mem_ack) begin
            mem_req_r <= 1'b0;
            done_r    <= 1'b1;
            state_r   <= S_IDLE;
          end
        end
        default: begin
          state_r <= S_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// *** frame_builder_assertions.sv ***
// Port checker for the frame builder.
// Assumes it is bound to every frame_builder instance.
`timescale 1ns/100ps
`default_nettype none
module frame_builder_checker (
  input wire logic        clk, rstn, enter_req, leave_req, cmd_ready, done_r,
  input wire logic        mem_req_r, mem_we_r, mem_ack, base_is_frame_reg, use_stack_seg,
  input wire logic [15:0] storage_bytes,
  input wire logic [4:0]  nest_level,
  input wire logic [31:0] mem_addr_r, mem_wdata_r, mem_rdata,
  input wire logic [31:0] frame_base_pointer, stack_top_pointer
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence s_enter; cmd_ready && enter_req; endsequence
  sequence s_leave; cmd_ready && leave_req && !enter_req; endsequence
  sequence s_push; mem_req_r && mem_we_r && mem_ack; endsequence
  property p_seg; use_stack_seg == base_is_frame_reg; endproperty
  property p_first; s_enter |=> mem_req_r && mem_we_r && mem_wdata_r == $past(frame_base_pointer)
    && mem_addr_r == $past(stack_top_pointer) - 32'h4; endproperty
  property p_leave; s_leave |=> mem_req_r && !mem_we_r && mem_addr_r == $past(frame_base_pointer);
  endproperty
  property p_step; s_push |=> stack_top_pointer == $past(stack_top_pointer) - 32'h4; endproperty
  property p_hold; mem_req_r && !mem_ack |=> mem_req_r && $stable(mem_addr_r)
    && $stable(mem_we_r) && $stable(mem_wdata_r); endproperty
  property p_busy; mem_req_r |-> !cmd_ready; endproperty
  property p_done_idle; done_r |-> !mem_req_r; endproperty
  property p_done_pulse; done_r |=> !done_r; endproperty
  property p_done_final; done_r |=> $stable(frame_base_pointer) && $stable(stack_top_pointer);
  endproperty
  a_seg: assert property (p_seg) else $error("segment select wrong");
  a_first: assert property (p_first) else $error("first push wrong");
  a_leave: assert property (p_leave) else $error("release read wrong");
  a_step: assert property (p_step) else $error("push step wrong");
  a_hold: assert property (p_hold) else $error("request not held");
  a_busy: assert property (p_busy) else $error("ready while busy");
  a_done_idle: assert property (p_done_idle) else $error("done with access open");
  a_done_pulse: assert property (p_done_pulse) else $error("done too long");
  a_done_final: assert property (p_done_final) else $error("pointers moved");
endmodule
bind frame_builder frame_builder_checker u_frame_builder_checker (.clk, .rstn, .enter_req,
  .leave_req, .cmd_ready, .done_r, .mem_req_r, .mem_we_r, .mem_ack, .base_is_frame_reg,
  .use_stack_seg, .storage_bytes, .nest_level, .mem_addr_r, .mem_wdata_r, .mem_rdata,
  .frame_base_pointer, .stack_top_pointer);
`default_nettype wire

// *** stack_mem.sv ***
// Stack memory partner answering one access at a time.
// Assumes requests held until acknowledged, on the same clock.
`timescale 1ns/100ps
`default_nettype none
module stack_mem (
  input wire logic        clk, slow, mem_req_r, mem_we_r,
  input wire logic [31:0] mem_addr_r, mem_wdata_r,
  output logic            mem_ack,
  output logic [31:0]     mem_rdata
);
  logic [31:0] mem [logic [31:0]];
  logic [1:0]  wait_r = 2'h0;
  initial mem_ack = 1'b0;
  initial mem_rdata = 32'h0;
  // Answers each access once, in order, at once or after three idle cycles.
  always @(posedge clk) begin
    if (mem_req_r && !mem_ack && !(slow && wait_r != 2'h3)) begin
      wait_r <= 2'h0;
      mem_ack <= #1 1'b1;
      if (mem_we_r) begin
        mem[mem_addr_r] = mem_wdata_r;
        mem_rdata <= #1 ~mem_rdata;
      end else begin
        mem_rdata <= #1 mem.exists(mem_addr_r) ? mem[mem_addr_r] : ~mem_addr_r;
      end
    end else begin
      if (mem_req_r && !mem_ack) wait_r <= wait_r + 2'h1;
      mem_ack <= #1 1'b0;
      mem_rdata <= #1 ~mem_rdata;
    end
  end
endmodule
`default_nettype wire

// *** frame_builder_test.sv ***
// Self-checking bench for the frame builder.
// Assumes pointers start at zero and memory is the stack_mem partner.
`timescale 1ns/100ps
`default_nettype none
module frame_builder_test;
  logic clk = 1'b0, rstn = 1'b0, enter_req = 1'b0, leave_req = 1'b0, slow = 1'b0;
  logic base_is_frame_reg = 1'b0;
  logic [15:0] storage_bytes = 16'h0;
  logic [4:0] nest_level = 5'h0;
  wire logic cmd_ready, done_r, mem_req_r, mem_we_r, mem_ack, use_stack_seg;
  wire logic [31:0] mem_addr_r, mem_wdata_r, mem_rdata, frame_base_pointer, stack_top_pointer;
  logic [31:0] fb_m = 32'h0, st_m = 32'h0;
  logic [31:0] mem_m [logic [31:0]];
  integer failures = 0, samples_checked = 0, cyc = 0, seed = 32'h67bd, i;
  always #25 clk = ~clk;
  frame_builder u_frame_builder (.clk, .rstn, .enter_req, .leave_req, .storage_bytes,
    .nest_level, .cmd_ready, .done_r, .mem_req_r, .mem_we_r, .mem_addr_r, .mem_wdata_r,
    .mem_ack, .mem_rdata, .frame_base_pointer, .stack_top_pointer, .base_is_frame_reg,
    .use_stack_seg);
  stack_mem u_stack_mem (.clk, .slow, .mem_req_r, .mem_we_r, .mem_addr_r, .mem_wdata_r,
    .mem_ack, .mem_rdata);
  always @(posedge clk) begin
    #1 base_is_frame_reg = 1'($random(seed));
    #1 chk({31'h0, use_stack_seg}, {31'h0, base_is_frame_reg});
  end
  task automatic final_report();
    $display("checked %0d, failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 50000) begin
      failures++;
      final_report();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  function automatic void ref_enter(input logic [15:0] sb, input logic [4:0] lv);
    logic [31:0] fp, b;
    fp = st_m - 32'h4;
    b = fb_m;
    mem_m[fp] = fb_m;
    st_m = fp;
    for (int k = 1; k < lv; k++) begin
      b = b - 32'h4;
      st_m = st_m - 32'h4;
      mem_m[st_m] = mem_m.exists(b) ? mem_m[b] : ~b;
    end
    if (lv != 5'h0) begin
      st_m = st_m - 32'h4;
      mem_m[st_m] = fp;
    end
    fb_m = fp;
    st_m = st_m - {16'h0, sb};
  endfunction
  function automatic void ref_leave();
    logic [31:0] b;
    b = fb_m;
    fb_m = mem_m.exists(b) ? mem_m[b] : ~b;
    st_m = b + 32'h4;
  endfunction
  task automatic run(input logic op, input logic [15:0] sb, input logic [4:0] lv);
    integer n;
    if (op) ref_enter(sb, lv);
    else ref_leave();
    @(posedge clk) #1;
    enter_req = op;
    leave_req = !op | 1'($random(seed));
    storage_bytes = sb;
    nest_level = lv;
    slow = 1'($random(seed));
    @(posedge clk) #1;
    enter_req = 1'b0;
    leave_req = 1'b0;
    chk({31'h0, cmd_ready}, 32'h0);
    n = 0;
    while (done_r !== 1'b1 && n < 400) begin
      @(posedge clk) #1;
      n++;
    end
    chk({31'h0, done_r}, 32'h1);
    chk({31'h0, cmd_ready}, 32'h1);
    chk(frame_base_pointer, fb_m);
    chk(stack_top_pointer, st_m);
    foreach (mem_m[a]) chk(u_stack_mem.mem[a], mem_m[a]);
  endtask
  initial begin
    repeat (2) @(posedge clk);
    #1 rstn = 1'b1;
    repeat (3) @(posedge clk);
    run(1'b1, 16'h0, 5'h0);
    run(1'b1, 16'h000c, 5'h1);
    run(1'b1, 16'h0800, 5'h2);
    run(1'b1, 16'h0010, 5'h2);
    run(1'b1, 16'hffff, 5'h2);
    run(1'b1, 16'h0004, 5'h1f);
    run(1'b0, 16'h0, 5'h0);
    for (i = 0; i < 40; i++) run(1'($random(seed)), 16'($random(seed)), 5'($random(seed)) % 5'h6);
    final_report();
  end
endmodule
`default_nettype wire
